// file: design/epb_buffer.v
`include "epb_consts.vh"

// Function
// [RL1] one 8-Kbyte packet memory split by pointers into receive and transmit regions
// [RL2] memory, data window and pointers always reachable, independent of module enable
// [RL3] receive region spans start pointer through end pointer, both inclusive
// [RL4] received bytes stored sequentially, wrapping from end pointer back to start
// [RL5] host changes receive start and end only while reception is disabled
// [RL6] receive write pointer is read-only, updated when an accepted packet completes
// [RL7] receive logic never writes the byte at the protect pointer
// [RL8] when region is full, new incoming data is discarded, old kept
// [RL9] host advances protect pointer after processing received data
// [RL10] memory outside receive region is transmit; host sets transmit start and end
// [RL11] no overlap check; host keeps transmit pointers clear of receive region
// [RL12] data window writes go to write pointer, reads come from read pointer
// [RL13] auto-increment advances read or write pointer by one per window access
// [RL14] window read at receive end moves read pointer to receive start
// [RL15] host writes never wrap; write pointer simply increments
// [RL16] dma reads wrap at receive end like host reads; dma writes never wrap
// [RL17] control bits 7 and 6 hold transmit and receive logic in reset
// [RL18] control bit 5 starts dma, cleared by hardware on finish or software
// [RL19] control bit 4 selects checksum when 1, copy when 0
// [RL20] control bit 3 requests transmit, cleared by hardware on end or software
// [RL21] control bit 2 enables storing filtered packets; zero discards all packets
// [RL22] control bits 1 and 0 read as zero
// [RL23] pointers are 13 bits, split into high and low host bytes
module epb_buffer
(
  input  wire                   core_clk,
  input  wire                   reset,
  input  wire [`EPB_SEL_W-1:0]  host_sel,
  input  wire                   host_wr,
  input  wire                   host_rd,
  input  wire [`EPB_DATA_W-1:0] host_wdata,
  output reg  [`EPB_DATA_W-1:0] host_rdata,
  input  wire                   rx_byte_valid,
  input  wire [`EPB_DATA_W-1:0] rx_byte_data,
  input  wire                   rx_pkt_first,
  input  wire                   rx_pkt_last,
  input  wire                   rx_pkt_pass,
  output reg                    rx_pkt_committed,
  output reg                    rx_pkt_dropped,
  output reg                    rx_busy,
  input  wire                   dma_rd_req,
  input  wire [`EPB_ADDR_W-1:0] dma_rd_addr,
  output reg  [`EPB_DATA_W-1:0] dma_rd_data,
  output reg  [`EPB_ADDR_W-1:0] dma_rd_next_addr,
  input  wire                   dma_wr_req,
  input  wire [`EPB_ADDR_W-1:0] dma_wr_addr,
  input  wire [`EPB_DATA_W-1:0] dma_wr_data,
  input  wire                   dma_done,
  input  wire                   tx_done,
  output wire                   tx_logic_reset,
  output wire                   rx_logic_reset,
  output wire                   dma_start_busy,
  output wire                   dma_checksum_select,
  output wire                   tx_request,
  output wire                   rx_accept_enable,
  output wire [`EPB_ADDR_W-1:0] tx_packet_start_ptr,
  output wire [`EPB_ADDR_W-1:0] tx_packet_end_ptr
);

  // ****************************************
  // storage
  // ****************************************
  reg  [`EPB_DATA_W-1:0] mem [0:`EPB_MEM_DEPTH-1]; // RL1
  reg  [7:0]             ethernet_main_control;
  reg                    ptr_auto_increment;
  reg  [`EPB_ADDR_W-1:0] host_read_ptr;
  reg  [`EPB_ADDR_W-1:0] host_write_ptr;
  reg  [`EPB_ADDR_W-1:0] rx_region_start_ptr;
  reg  [`EPB_ADDR_W-1:0] rx_region_end_ptr;
  reg  [`EPB_ADDR_W-1:0] rx_hw_write_ptr;
  reg  [`EPB_ADDR_W-1:0] rx_protect_ptr;
  reg  [`EPB_ADDR_W-1:0] tx_start_reg;
  reg  [`EPB_ADDR_W-1:0] tx_end_reg;
  reg  [`EPB_ADDR_W-1:0] rx_cursor;
  reg                    rx_in_pkt;
  reg                    rx_drop;
  reg  [`EPB_DATA_W-1:0] next_rdata;

  wire [`EPB_ADDR_W-1:0] host_rd_next;
  wire [`EPB_ADDR_W-1:0] dma_next;
  wire [`EPB_ADDR_W-1:0] rx_next;
  wire [`EPB_ADDR_W-1:0] host_wr_next;
  wire [`EPB_ADDR_W-1:0] rx_base;
  wire                   win_wr;
  wire                   win_rd;
  wire                   rx_active;
  wire                   rx_drop_now;
  wire                   rx_full;
  wire                   rx_store;
  wire                   start_lo_wr;
  wire                   start_hi_wr;

  assign tx_logic_reset      = ethernet_main_control[`EPB_CTRL_TX_RST]; // RL17
  assign rx_logic_reset      = ethernet_main_control[`EPB_CTRL_RX_RST]; // RL17
  assign dma_start_busy      = ethernet_main_control[`EPB_CTRL_DMA_GO];
  assign dma_checksum_select = ethernet_main_control[`EPB_CTRL_CSUM]; // RL19
  assign tx_request          = ethernet_main_control[`EPB_CTRL_TX_REQ];
  assign rx_accept_enable    = ethernet_main_control[`EPB_CTRL_RX_EN];
  assign tx_packet_start_ptr = tx_start_reg; // RL10
  assign tx_packet_end_ptr   = tx_end_reg; // RL10

  // ****************************************
  // address steppers
  // ****************************************
  epb_wrap_step u_host_rd_step
  (
    .cur_ptr      (host_read_ptr),
    .region_start (rx_region_start_ptr),
    .region_end   (rx_region_end_ptr),
    .next_ptr     (host_rd_next)
  );

  epb_wrap_step u_dma_rd_step
  (
    .cur_ptr      (dma_rd_addr),
    .region_start (rx_region_start_ptr),
    .region_end   (rx_region_end_ptr),
    .next_ptr     (dma_next)
  );

  epb_wrap_step u_rx_step
  (
    .cur_ptr      (rx_base),
    .region_start (rx_region_start_ptr),
    .region_end   (rx_region_end_ptr),
    .next_ptr     (rx_next)
  );

  assign host_wr_next = host_write_ptr + {{(`EPB_ADDR_W-1){1'b0}}, 1'b1}; // RL15

  // ****************************************
  // host access decode
  // ****************************************
  assign win_wr      = host_wr & (host_sel == `EPB_SEL_DATA_WIN);
  assign win_rd      = host_rd & (host_sel == `EPB_SEL_DATA_WIN);
  assign start_lo_wr = host_wr & (host_sel == `EPB_SEL_RXST_L);
  assign start_hi_wr = host_wr & (host_sel == `EPB_SEL_RXST_H);

  // ****************************************
  // receive path decode
  // ****************************************
  assign rx_base     = rx_pkt_first ? rx_hw_write_ptr : rx_cursor;
  assign rx_active   = (rx_pkt_first | rx_in_pkt) & rx_accept_enable & ~rx_logic_reset; // RL21
  assign rx_drop_now = rx_pkt_first ? 1'b0 : rx_drop;
  assign rx_full     = (rx_base == rx_protect_ptr); // RL7
  assign rx_store    = rx_byte_valid & rx_active & ~rx_drop_now & ~rx_full; // RL8

  // ****************************************
  // packet memory writes
  // ****************************************
  always @(posedge core_clk)
  begin
    if (rx_store)
    begin
      mem[rx_base] <= rx_byte_data; // RL4
    end
    if (dma_wr_req)
    begin
      mem[dma_wr_addr] <= dma_wr_data; // RL16
    end
    if (win_wr)
    begin
      mem[host_write_ptr] <= host_wdata; // RL12
    end
  end

  // ****************************************
  // dma read port
  // ****************************************
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      dma_rd_data      <= 8'h00;
      dma_rd_next_addr <= `EPB_RST_PTR;
    end
    else if (dma_rd_req)
    begin
      dma_rd_data      <= mem[dma_rd_addr];
      dma_rd_next_addr <= dma_next; // RL16
    end
  end

  // ****************************************
  // host read mux
  // ****************************************
  always @*
  begin
    next_rdata = 8'h00;
    case (host_sel)
      `EPB_SEL_MAIN_CTRL: next_rdata = {ethernet_main_control[7:2], 2'b00}; // RL22
      `EPB_SEL_AUX_CTRL:  next_rdata = {ptr_auto_increment, 7'h00};
      `EPB_SEL_DATA_WIN:  next_rdata = mem[host_read_ptr]; // RL12
      `EPB_SEL_HRD_L:     next_rdata = host_read_ptr[7:0]; // RL23
      `EPB_SEL_HRD_H:     next_rdata = {3'b000, host_read_ptr[12:8]}; // RL23
      `EPB_SEL_HWR_L:     next_rdata = host_write_ptr[7:0];
      `EPB_SEL_HWR_H:     next_rdata = {3'b000, host_write_ptr[12:8]};
      `EPB_SEL_RXST_L:    next_rdata = rx_region_start_ptr[7:0];
      `EPB_SEL_RXST_H:    next_rdata = {3'b000, rx_region_start_ptr[12:8]};
      `EPB_SEL_RXND_L:    next_rdata = rx_region_end_ptr[7:0];
      `EPB_SEL_RXND_H:    next_rdata = {3'b000, rx_region_end_ptr[12:8]};
      `EPB_SEL_RXWR_L:    next_rdata = rx_hw_write_ptr[7:0];
      `EPB_SEL_RXWR_H:    next_rdata = {3'b000, rx_hw_write_ptr[12:8]};
      `EPB_SEL_RXPR_L:    next_rdata = rx_protect_ptr[7:0];
      `EPB_SEL_RXPR_H:    next_rdata = {3'b000, rx_protect_ptr[12:8]};
      `EPB_SEL_TXST_L:    next_rdata = tx_start_reg[7:0];
      `EPB_SEL_TXST_H:    next_rdata = {3'b000, tx_start_reg[12:8]};
      `EPB_SEL_TXND_L:    next_rdata = tx_end_reg[7:0];
      `EPB_SEL_TXND_H:    next_rdata = {3'b000, tx_end_reg[12:8]};
      default:            next_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      host_rdata <= 8'h00;
    end
    else if (host_rd)
    begin
      host_rdata <= next_rdata; // RL2
    end
  end

  // ****************************************
  // host registers and pointers
  // ****************************************
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ethernet_main_control <= `EPB_RST_MAIN_CTRL;
      ptr_auto_increment    <= `EPB_RST_PTR_AUTO_INCREMENT;
      host_read_ptr         <= `EPB_RST_PTR;
      host_write_ptr        <= `EPB_RST_PTR;
      rx_region_start_ptr   <= `EPB_RST_RX_START;
      rx_region_end_ptr     <= `EPB_RST_RX_END;
      rx_protect_ptr        <= `EPB_RST_PTR;
      tx_start_reg          <= `EPB_RST_PTR;
      tx_end_reg            <= `EPB_RST_PTR;
    end
    else
    begin
      // hardware ends of dma and transmit; a software write below overrides
      if (dma_done)
      begin
        ethernet_main_control[`EPB_CTRL_DMA_GO] <= 1'b0; // RL18
      end
      if (tx_done | tx_logic_reset)
      begin
        ethernet_main_control[`EPB_CTRL_TX_REQ] <= 1'b0; // RL20
      end
      if (win_rd & ptr_auto_increment)
      begin
        host_read_ptr <= host_rd_next; // RL13 RL14
      end
      if (win_wr & ptr_auto_increment)
      begin
        host_write_ptr <= host_wr_next; // RL13
      end
      if (host_wr)
      begin
        case (host_sel)
          `EPB_SEL_MAIN_CTRL: ethernet_main_control <= {host_wdata[7:2], 2'b00}; // RL22
          `EPB_SEL_AUX_CTRL:  ptr_auto_increment <= host_wdata[`EPB_AUX_PTR_AUTO_INCREMENT];
          `EPB_SEL_HRD_L:     host_read_ptr[7:0] <= host_wdata; // RL23
          `EPB_SEL_HRD_H:     host_read_ptr[12:8] <= host_wdata[`EPB_HI_W-1:0]; // RL23
          `EPB_SEL_HWR_L:     host_write_ptr[7:0] <= host_wdata;
          `EPB_SEL_HWR_H:     host_write_ptr[12:8] <= host_wdata[`EPB_HI_W-1:0];
          `EPB_SEL_RXST_L:    rx_region_start_ptr[7:0] <= host_wdata; // RL3
          `EPB_SEL_RXST_H:    rx_region_start_ptr[12:8] <= host_wdata[`EPB_HI_W-1:0];
          `EPB_SEL_RXND_L:    rx_region_end_ptr[7:0] <= host_wdata; // RL3
          `EPB_SEL_RXND_H:    rx_region_end_ptr[12:8] <= host_wdata[`EPB_HI_W-1:0];
          `EPB_SEL_RXPR_L:    rx_protect_ptr[7:0] <= host_wdata;
          `EPB_SEL_RXPR_H:    rx_protect_ptr[12:8] <= host_wdata[`EPB_HI_W-1:0];
          `EPB_SEL_TXST_L:    tx_start_reg[7:0] <= host_wdata;
          `EPB_SEL_TXST_H:    tx_start_reg[12:8] <= host_wdata[`EPB_HI_W-1:0];
          `EPB_SEL_TXND_L:    tx_end_reg[7:0] <= host_wdata;
          `EPB_SEL_TXND_H:    tx_end_reg[12:8] <= host_wdata[`EPB_HI_W-1:0];
          default:            ptr_auto_increment <= ptr_auto_increment;
        endcase
      end
    end
  end

  // ****************************************
  // receive fifo engine
  // ****************************************
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      rx_hw_write_ptr  <= `EPB_RST_RX_START;
      rx_cursor        <= `EPB_RST_RX_START;
      rx_in_pkt        <= 1'b0;
      rx_drop          <= 1'b0;
      rx_busy          <= 1'b0;
      rx_pkt_committed <= 1'b0;
      rx_pkt_dropped   <= 1'b0;
    end
    else
    begin
      rx_pkt_committed <= 1'b0;
      rx_pkt_dropped   <= 1'b0;
      if (rx_logic_reset)
      begin
        // held in reset: abandon any packet, restart at region start
        rx_hw_write_ptr <= rx_region_start_ptr; // RL17
        rx_cursor       <= rx_region_start_ptr;
        rx_pkt_dropped  <= rx_byte_valid & rx_pkt_last; // RL17
        rx_in_pkt       <= 1'b0;
        rx_drop         <= 1'b0;
        rx_busy         <= 1'b0;
      end
      else
      begin
        if (~rx_accept_enable & ~rx_in_pkt & start_lo_wr)
        begin
          rx_hw_write_ptr[7:0] <= host_wdata;
        end
        if (~rx_accept_enable & ~rx_in_pkt & start_hi_wr)
        begin
          rx_hw_write_ptr[12:8] <= host_wdata[`EPB_HI_W-1:0];
        end
        if (rx_byte_valid)
        begin
          if (rx_store)
          begin
            rx_cursor <= rx_next; // RL4
          end
          else
          begin
            rx_cursor <= rx_base;
          end
          if (rx_active & (rx_drop_now | rx_full))
          begin
            rx_drop <= 1'b1; // RL8
          end
          else if (rx_pkt_first)
          begin
            rx_drop <= 1'b0;
          end
          if (rx_pkt_last)
          begin
            rx_in_pkt <= 1'b0;
            rx_busy   <= 1'b0;
            if (rx_store & rx_pkt_pass)
            begin
              rx_hw_write_ptr  <= rx_next; // RL6
              rx_pkt_committed <= 1'b1;
            end
            else
            begin
              rx_pkt_dropped <= 1'b1; // RL21
            end
          end
          else
          begin
            rx_in_pkt <= rx_active;
            rx_busy   <= rx_active;
          end
        end
        else if (~rx_accept_enable)
        begin
          rx_in_pkt <= 1'b0;
          rx_busy   <= 1'b0;
        end
      end
    end
  end

endmodule

// file: design/epb_consts.vh
`ifndef EPB_CONSTS_VH
`define EPB_CONSTS_VH

// ****************************************
// memory geometry
// ****************************************
`define EPB_ADDR_W        13
`define EPB_MEM_DEPTH     8192
`define EPB_DATA_W        8
`define EPB_HI_W          5

// ****************************************
// host register select codes
// ****************************************
`define EPB_SEL_W         5
`define EPB_SEL_MAIN_CTRL 5'h00
`define EPB_SEL_AUX_CTRL  5'h01
`define EPB_SEL_DATA_WIN  5'h02
`define EPB_SEL_HRD_L     5'h03
`define EPB_SEL_HRD_H     5'h04
`define EPB_SEL_HWR_L     5'h05
`define EPB_SEL_HWR_H     5'h06
`define EPB_SEL_RXST_L    5'h07
`define EPB_SEL_RXST_H    5'h08
`define EPB_SEL_RXND_L    5'h09
`define EPB_SEL_RXND_H    5'h0a
`define EPB_SEL_RXWR_L    5'h0b
`define EPB_SEL_RXWR_H    5'h0c
`define EPB_SEL_RXPR_L    5'h0d
`define EPB_SEL_RXPR_H    5'h0e
`define EPB_SEL_TXST_L    5'h0f
`define EPB_SEL_TXST_H    5'h10
`define EPB_SEL_TXND_L    5'h11
`define EPB_SEL_TXND_H    5'h12

// ****************************************
// main and aux control fields
// ****************************************
`define EPB_CTRL_TX_RST   7
`define EPB_CTRL_RX_RST   6
`define EPB_CTRL_DMA_GO   5
`define EPB_CTRL_CSUM     4
`define EPB_CTRL_TX_REQ   3
`define EPB_CTRL_RX_EN    2
`define EPB_AUX_PTR_AUTO_INCREMENT   7

// ****************************************
// reset values
// ****************************************
`define EPB_RST_MAIN_CTRL 8'h00
`define EPB_RST_PTR_AUTO_INCREMENT   1'b1
`define EPB_RST_RX_START  13'h0000
`define EPB_RST_RX_END    13'h1fff
`define EPB_RST_PTR       13'h0000

`endif

// file: design/epb_wrap_step.v
`include "epb_consts.vh"

// ****************************************
// next sequential address, wrapping at the receive end
// ****************************************
module epb_wrap_step
(
  input  wire [`EPB_ADDR_W-1:0] cur_ptr,
  input  wire [`EPB_ADDR_W-1:0] region_start,
  input  wire [`EPB_ADDR_W-1:0] region_end,
  output wire [`EPB_ADDR_W-1:0] next_ptr
);

  wire [`EPB_ADDR_W-1:0] plus_one;

  assign plus_one = cur_ptr + {{(`EPB_ADDR_W-1){1'b0}}, 1'b1};
  assign next_ptr = (cur_ptr == region_end) ? region_start : plus_one;

endmodule

// file: verification/epb_sva.sv
`include "epb_consts.vh"
module epb_sva
(
  input wire                   core_clk,
  input wire                   reset,
  input wire [`EPB_SEL_W-1:0]  host_sel,
  input wire                   host_wr,
  input wire                   host_rd,
  input wire [`EPB_DATA_W-1:0] host_wdata,
  input wire [`EPB_DATA_W-1:0] host_rdata,
  input wire                   rx_byte_valid,
  input wire                   rx_pkt_first,
  input wire                   rx_pkt_last,
  input wire                   rx_pkt_pass,
  input wire                   rx_pkt_committed,
  input wire                   rx_pkt_dropped,
  input wire                   dma_done,
  input wire                   tx_done,
  input wire                   tx_logic_reset,
  input wire                   rx_logic_reset,
  input wire                   dma_start_busy,
  input wire                   dma_checksum_select,
  input wire                   tx_request,
  input wire                   rx_accept_enable,
  input wire [`EPB_ADDR_W-1:0] tx_packet_start_ptr,
  input wire                   rx_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire       ctl_wr = host_wr && host_sel == `EPB_SEL_MAIN_CTRL;
  wire [5:0] ctl    = {tx_logic_reset, rx_logic_reset, dma_start_busy,
                       dma_checksum_select, tx_request, rx_accept_enable};
  // ****************************************
  // sequences
  // ****************************************
  sequence s_lone_off;
    rx_byte_valid && rx_pkt_first && rx_pkt_last && !rx_accept_enable;
  endsequence
  sequence s_drop;
    rx_pkt_dropped && !rx_pkt_committed;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  property p_ctl_wr;
    ctl_wr |=> ctl == $past(host_wdata[7:2]);
  endproperty
  property p_ctl_rd;
    host_rd && host_sel == `EPB_SEL_MAIN_CTRL |=> host_rdata == {$past(ctl), 2'b00};
  endproperty
  property p_dma_clr;
    dma_done && !ctl_wr |=> !dma_start_busy;
  endproperty
  property p_dma_hold;
    dma_start_busy && !dma_done && !ctl_wr |=> dma_start_busy;
  endproperty
  property p_tx_clr;
    tx_done && !ctl_wr |=> !tx_request;
  endproperty
  property p_tx_logic_reset;
    tx_logic_reset && !ctl_wr |=> !tx_request;
  endproperty
  property p_lone_off;
    s_lone_off |=> s_drop;
  endproperty
  property p_commit;
    rx_pkt_committed |-> $past(rx_byte_valid && rx_pkt_last && rx_pkt_pass);
  endproperty
  property p_filt;
    rx_byte_valid && rx_pkt_last && !rx_pkt_pass |=> s_drop;
  endproperty
  property p_busy;
    rx_byte_valid && rx_pkt_first && !rx_pkt_last && rx_accept_enable && !rx_logic_reset
      |=> rx_busy;
  endproperty
  property p_txst;
    host_wr && host_sel == `EPB_SEL_TXST_L |=> tx_packet_start_ptr[7:0] == $past(host_wdata);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read wrong");
  a_dma_clr: assert property (p_dma_clr) else $error("dma busy kept");
  a_dma_hold: assert property (p_dma_hold) else $error("dma busy lost");
  a_tx_clr: assert property (p_tx_clr) else $error("tx request kept");
  a_tx_logic_reset: assert property (p_tx_logic_reset) else $error("tx request in reset");
  a_lone_off: assert property (p_lone_off) else $error("disabled packet kept");
  a_commit: assert property (p_commit) else $error("commit without cause");
  a_filt: assert property (p_filt) else $error("filtered packet kept");
  a_txst: assert property (p_txst) else $error("tx start not loaded");
  a_busy: assert property (p_busy) else $error("rx busy not raised");
endmodule

// file: verification/epb_far_model.sv
`include "epb_consts.vh"
module epb_far_model
(
  input  wire                    core_clk,
  input  wire                    rx_pkt_committed,
  input  wire                    rx_pkt_dropped,
  input  wire  [`EPB_DATA_W-1:0] dma_rd_data,
  input  wire  [`EPB_ADDR_W-1:0] dma_rd_next_addr,
  output logic                   rx_byte_valid,
  output logic [`EPB_DATA_W-1:0] rx_byte_data,
  output logic                   rx_pkt_first,
  output logic                   rx_pkt_last,
  output logic                   rx_pkt_pass,
  output logic                   dma_rd_req,
  output logic [`EPB_ADDR_W-1:0] dma_rd_addr,
  output logic                   dma_wr_req,
  output logic [`EPB_ADDR_W-1:0] dma_wr_addr,
  output logic [`EPB_DATA_W-1:0] dma_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {rx_byte_valid, rx_pkt_first, rx_pkt_last, rx_pkt_pass} = 4'h0;
    {dma_rd_req, dma_wr_req} = 2'b00;
    rx_byte_data = 8'h00;
    dma_rd_addr = 13'h0000;
    dma_wr_addr = 13'h0000;
    dma_wr_data = 8'h00;
  end
  // bytes back to back; verdict pulses sampled one cycle after the last
  task automatic send_pkt(input logic [7:0] base, input int n, input logic pass,
                          output logic comm, output logic drop);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      #1;
      rx_byte_valid = 1'b1;
      rx_byte_data = base + 8'(i);
      rx_pkt_first = (i == 0);
      rx_pkt_last = (i == n - 1);
      rx_pkt_pass = pass;
    end
    @(posedge core_clk);
    #1;
    comm = rx_pkt_committed;
    drop = rx_pkt_dropped;
    {rx_byte_valid, rx_pkt_first, rx_pkt_last} = 3'b000;
    rx_byte_data = ~rx_byte_data;
  endtask
  task automatic dma_rd(input logic [12:0] a, output logic [7:0] d, output logic [12:0] na);
    @(posedge core_clk);
    #1;
    dma_rd_req = 1'b1;
    dma_rd_addr = a;
    @(posedge core_clk);
    #1;
    d = dma_rd_data;
    na = dma_rd_next_addr;
    dma_rd_req = 1'b0;
    dma_rd_addr = ~a;
  endtask
  task automatic dma_wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    dma_wr_req = 1'b1;
    dma_wr_addr = a;
    dma_wr_data = d;
    @(posedge core_clk);
    #1;
    dma_wr_req = 1'b0;
    dma_wr_data = ~d;
  endtask
endmodule

// file: verification/tb.sv
`include "epb_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, reset, host_wr, host_rd, dma_done, tx_done;
  logic [4:0]  host_sel;
  logic [7:0]  host_wdata, rv;
  logic [12:0] pv;
  logic        cm, dr;
  wire  [7:0]  host_rdata, rx_byte_data, dma_rd_data, dma_wr_data;
  wire  [12:0] dma_rd_addr, dma_rd_next_addr, dma_wr_addr, tx_packet_start_ptr, tx_packet_end_ptr;
  wire         rx_byte_valid, rx_pkt_first, rx_pkt_last, rx_pkt_pass, rx_pkt_committed;
  wire         rx_pkt_dropped, rx_busy, dma_rd_req, dma_wr_req, tx_logic_reset, rx_logic_reset;
  wire         dma_start_busy, dma_checksum_select, tx_request, rx_accept_enable;
  int          err_count, comparisons;
  epb_buffer epb_buffer_i (.core_clk, .reset, .host_sel, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .rx_byte_valid, .rx_byte_data, .rx_pkt_first, .rx_pkt_last, .rx_pkt_pass,
    .rx_pkt_committed, .rx_pkt_dropped, .rx_busy, .dma_rd_req, .dma_rd_addr, .dma_rd_data,
    .dma_rd_next_addr, .dma_wr_req, .dma_wr_addr, .dma_wr_data, .dma_done, .tx_done,
    .tx_logic_reset, .rx_logic_reset, .dma_start_busy, .dma_checksum_select, .tx_request,
    .rx_accept_enable, .tx_packet_start_ptr, .tx_packet_end_ptr);
  epb_far_model epb_far_model_i (.core_clk, .rx_pkt_committed, .rx_pkt_dropped, .dma_rd_data,
    .dma_rd_next_addr, .rx_byte_valid, .rx_byte_data, .rx_pkt_first, .rx_pkt_last,
    .rx_pkt_pass, .dma_rd_req, .dma_rd_addr, .dma_wr_req, .dma_wr_addr, .dma_wr_data);
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    host_sel = s;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge core_clk);
    #1;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] s, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    host_sel = s;
    host_rd = 1'b1;
    @(posedge core_clk);
    #1;
    d = host_rdata;
    host_rd = 1'b0;
  endtask
  task automatic rc(input logic [4:0] s, input logic [7:0] e);
    logic [7:0] d;
    rd(s, d);
    chk($sformatf("register %h", s), {5'h00, e}, {5'h00, d});
  endtask
  task automatic wp(input logic [4:0] s, input logic [12:0] v);
    wr(s, v[7:0]);
    wr(s + 5'h01, {3'b000, v[12:8]});
  endtask
  task automatic pc(input logic [4:0] s, input logic [12:0] e);
    logic [7:0] lo, hi;
    rd(s, lo);
    rd(s + 5'h01, hi);
    chk($sformatf("pointer %h", s), e, {hi[4:0], lo});
  endtask
  task automatic done_pulse(input logic [1:0] w);
    @(posedge core_clk);
    #1;
    {dma_done, tx_done} = w;
    @(posedge core_clk);
    #1;
    {dma_done, tx_done} = 2'b00;
  endtask
  task automatic pkt(input logic [7:0] b, input int n, input logic p, input logic [1:0] e);
    epb_far_model_i.send_pkt(b, n, p, cm, dr);
    chk("commit and drop", {11'h000, e}, {11'h000, cm, dr});
  endtask
  task automatic close_out;
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    close_out;
  end
  initial
  begin
    {reset, host_wr, host_rd, dma_done, tx_done} = 5'b10000;
    host_sel = 5'h00;
    host_wdata = 8'h00;
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    rc(`EPB_SEL_MAIN_CTRL, 8'h00);
    rc(`EPB_SEL_AUX_CTRL, 8'h80);
    pc(`EPB_SEL_RXND_L, 13'h1fff);
    rc(5'h1f, 8'h00);
    wr(`EPB_SEL_MAIN_CTRL, 8'h37);
    rc(`EPB_SEL_MAIN_CTRL, 8'h34);
    done_pulse(2'b10);
    rc(`EPB_SEL_MAIN_CTRL, 8'h14);
    wr(`EPB_SEL_MAIN_CTRL, 8'h08);
    done_pulse(2'b01);
    rc(`EPB_SEL_MAIN_CTRL, 8'h00);
    wr(`EPB_SEL_MAIN_CTRL, 8'h88);
    rc(`EPB_SEL_MAIN_CTRL, 8'h80);
    wr(`EPB_SEL_MAIN_CTRL, 8'h40);
    rc(`EPB_SEL_MAIN_CTRL, 8'h40);
    wr(`EPB_SEL_MAIN_CTRL, 8'h00);
    wp(`EPB_SEL_RXST_L, 13'h0100);
    wp(`EPB_SEL_RXND_L, 13'h0103);
    wr(`EPB_SEL_RXWR_L, 8'h55);
    pc(`EPB_SEL_RXWR_L, 13'h0100);
    wp(`EPB_SEL_HWR_L, 13'h0100);
    for (int i = 0; i < 6; i++) wr(`EPB_SEL_DATA_WIN, 8'ha0 + 8'(i));
    pc(`EPB_SEL_HWR_L, 13'h0106);
    wp(`EPB_SEL_HRD_L, 13'h0100);
    for (int i = 0; i < 5; i++)
    begin
      rd(`EPB_SEL_DATA_WIN, rv);
      chk("window read", 13'h00a0 + 13'(i % 4), {5'h00, rv});
    end
    pc(`EPB_SEL_HRD_L, 13'h0101);
    wr(`EPB_SEL_AUX_CTRL, 8'h00);
    rd(`EPB_SEL_DATA_WIN, rv);
    pc(`EPB_SEL_HRD_L, 13'h0101);
    wr(`EPB_SEL_AUX_CTRL, 8'h80);
    wp(`EPB_SEL_TXST_L, 13'h1fff);
    rc(`EPB_SEL_TXST_H, 8'h1f);
    wp(`EPB_SEL_TXND_L, 13'h0040);
    chk("tx ptrs", 13'h0040, tx_packet_end_ptr ^ tx_packet_start_ptr ^ 13'h1fff);
    wp(`EPB_SEL_RXPR_L, 13'h0000);
    wr(`EPB_SEL_MAIN_CTRL, 8'h04);
    pkt(8'h10, 3, 1'b1, 2'b10);
    pc(`EPB_SEL_RXWR_L, 13'h0103);
    wp(`EPB_SEL_RXPR_L, 13'h0102);
    pkt(8'h20, 2, 1'b1, 2'b10);
    pc(`EPB_SEL_RXWR_L, 13'h0101);
    pkt(8'h30, 3, 1'b1, 2'b01);
    pc(`EPB_SEL_RXWR_L, 13'h0101);
    pkt(8'h40, 1, 1'b0, 2'b01);
    wr(`EPB_SEL_MAIN_CTRL, 8'h00);
    pkt(8'h50, 1, 1'b1, 2'b01);
    wp(`EPB_SEL_HRD_L, 13'h0102);
    for (int i = 0; i < 3; i++)
    begin
      rd(`EPB_SEL_DATA_WIN, rv);
      chk("stored byte", {5'h00, i == 0 ? 8'h12 : 8'h20 + 8'(i - 1)}, {5'h00, rv});
    end
    epb_far_model_i.dma_rd(13'h0103, rv, pv);
    chk("dma data", 13'h0020, {5'h00, rv});
    chk("dma next", 13'h0100, pv);
    epb_far_model_i.dma_rd(13'h0200, rv, pv);
    chk("dma next", 13'h0201, pv);
    epb_far_model_i.dma_wr(13'h0104, 8'h77);
    wp(`EPB_SEL_HRD_L, 13'h0104);
    rd(`EPB_SEL_DATA_WIN, rv);
    chk("dma write", 13'h0077, {5'h00, rv});
    close_out;
  end
endmodule
bind epb_buffer epb_sva epb_sva_i (.core_clk, .reset, .host_sel, .host_wr, .host_rd,
  .host_wdata, .host_rdata, .rx_byte_valid, .rx_pkt_first, .rx_pkt_last, .rx_pkt_pass,
  .rx_pkt_committed, .rx_pkt_dropped, .dma_done, .tx_done, .tx_logic_reset,
  .rx_logic_reset, .dma_start_busy, .dma_checksum_select, .tx_request, .rx_accept_enable,
  .tx_packet_start_ptr, .rx_busy);
